// File: iaa_ack_arb.v
`timescale 1ns/1ps
`include "iaa_defines.vh"

module iaa_ack_arb #(
   parameter NMOD    = 4,                      // Internal interrupt-capable modules
   parameter MON_CYC = `IAA_BUS_MON_CYC        // Bus monitor period in cycles
) (
   input  wire               ref_clk,
   input  wire               resetn,
   input  wire               clk_en,              // Freezes all state when low
   // External request pins, active low, asynchronous
   input  wire [7:1]         irq_pins_n,
   // Internal module requests
   input  wire [NMOD*3-1:0]  mod_level,           // Level of each module's request
   input  wire [NMOD*4-1:0]  mod_arb_wr_data,     // New arbitration values
   input  wire [NMOD-1:0]    mod_arb_wr,          // Write strobes for those values
   input  wire [NMOD*8-1:0]  mod_vector,          // Vector each module returns
   // Integration unit configuration
   input  wire [3:0]         siu_arb_wr_data,
   input  wire               siu_arb_wr,
   input  wire [2:0]         timer_request_level, // Zero disables the timer
   input  wire               timer_req,           // Periodic timer event pending
   // Processor side
   input  wire               instr_boundary,      // Boundary or higher exception done
   input  wire [31:0]        vector_base,
   input  wire [31:0]        pc_in,
   input  wire               sr_wr,               // Software load of the status register
   input  wire [15:0]        sr_wr_data,          // Value for that load
   // External bus answers
   input  wire               data_size_ack,       // Synchronous, same clock
   input  wire               autovector_request,
   input  wire [7:0]         ext_vector,
   input  wire               cs_ack_match,        // Chip-select programmed for level
   input  wire               cs_autovector,       // Chip-select answers with autovector
   // Outputs
   output reg  [2:0]         function_code_lines,
   output reg  [23:0]        ack_addr,
   output reg                ack_cycle,           // Acknowledge cycle on bus
   output reg                ext_forward,         // Cycle forwarded externally
   output reg                bus_error_line,
   output reg                stack_push,          // Pulse per stacked item
   output reg  [31:0]        stack_data,
   output reg  [15:0]        status_reg,
   output reg  [31:0]        vector_addr,
   output reg                pc_load,             // One-cycle pulse
   output reg  [7:0]         vector_num,
   output reg  [NMOD-1:0]    mod_ack,             // Internal winner strobe
   output reg                timer_ack,
   output reg  [NMOD*4-1:0]  mod_arb_field,
   output reg  [3:0]         siu_arb_field
);

   // ==================================================
   // States
   localparam ST_IDLE  = 3'h0;
   localparam ST_STACK = 3'h1;
   localparam ST_ACK   = 3'h2;
   localparam ST_ARB   = 3'h3;
   localparam ST_EXT   = 3'h4;
   localparam ST_VEC   = 3'h5;
   localparam ST_LOAD  = 3'h6;

   reg  [2:0]  state_r;                 // Sequencer state
   reg  [15:0] mon_cnt_r;               // Bus monitor counter
   reg  [2:0]  stk_cnt_r;               // Stacking step counter
   reg  [2:0]  lvl_r;                   // Level being acknowledged
   reg  [7:1]  irq_s1_r;                // First synchroniser stage
   reg  [7:1]  irq_s2_r;                // Second synchroniser stage
   reg  [7:1]  irq_s3_r;                // Hysteresis stage
   reg         nmi_prev_r;              // Last qualified level-7
   reg         nmi_pend_r;              // Level-7 edge latched
   reg  [2:0]  ipm_prev_r;              // Mask last cycle, for 7-to-lower

   wire [2:0]  ipm = status_reg[`IAA_SR_IPM_LSB+2:`IAA_SR_IPM_LSB];

   // ==================================================
   // Pin qualification: two flops then a two-cycle hysteresis stage
   // Only the second stage reads the first, keeping metastability contained
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         irq_s1_r <= 7'h7f;
         irq_s2_r <= 7'h7f;
         irq_s3_r <= 7'h7f;
      end else if (clk_en) begin
         irq_s1_r <= irq_pins_n;
         irq_s2_r <= irq_s1_r;
         irq_s3_r <= irq_s2_r;
      end
   end

   // Valid when low for two consecutive samples
   wire [7:1] pin_valid = ~irq_s2_r & ~irq_s3_r;

   // ==================================================
   // Pending level: modules, timer, pins
   reg  [7:0] lvl_req;                  // One bit per requested level
   integer    i;
   always @* begin
      lvl_req = 8'h00;
      for (i = 0; i < NMOD; i = i + 1)
         lvl_req[mod_level[i*3 +: 3]] = 1'b1;
      if (timer_req && timer_request_level != `IAA_LEVEL_OFF)
         lvl_req[timer_request_level] = 1'b1;
      lvl_req[6:1] = lvl_req[6:1] | pin_valid[6:1];
      lvl_req[7]   = lvl_req[7] | nmi_pend_r;
      lvl_req[0]   = 1'b0;
   end

   // Highest level above the mask; level 7 ignores the mask
   reg  [2:0] top_lvl;
   integer    k;
   always @* begin
      top_lvl = 3'h0;
      for (k = 1; k < 8; k = k + 1)
         if (lvl_req[k] && (k[2:0] > ipm || k == 7))
            top_lvl = k[2:0];
   end

   // ==================================================
   // Contention: each module joins only on level match
   // Ties keep the earlier contender; software must keep values distinct
   reg  [3:0]      best_arb;            // Highest contending value
   reg  [NMOD-1:0] best_mod;            // One-hot of internal winner
   reg             siu_contends;        // Timer or pin at the level
   reg             tmr_hit;
   integer         m;
   always @* begin
      tmr_hit = timer_req && timer_request_level == lvl_r &&
                timer_request_level != `IAA_LEVEL_OFF;
      siu_contends = tmr_hit || (lvl_r == `IAA_LEVEL_NMI ? nmi_pend_r : pin_valid[lvl_r]);
      best_arb = `IAA_ARB_NONE;
      best_mod = {NMOD{1'b0}};
      if (siu_contends)
         best_arb = siu_arb_field;
      for (m = 0; m < NMOD; m = m + 1)
         if (mod_level[m*3 +: 3] == lvl_r &&
             mod_arb_field[m*4 +: 4] > best_arb) begin
            best_arb = mod_arb_field[m*4 +: 4];
            best_mod = {NMOD{1'b0}};
            best_mod[m] = 1'b1;
         end
   end

   // One-hot winner selects its vector; zero when the unit itself wins
   reg [7:0] win_vec;                   // Vector of the internal winner
   integer   v;
   always @* begin
      win_vec = 8'h00;
      for (v = 0; v < NMOD; v = v + 1)
         if (best_mod[v])
            win_vec = mod_vector[v*8 +: 8];
   end

   // Autovector number follows the acknowledged level
   wire [7:0] auto_vec = `IAA_VEC_AUTO_BASE + {5'h00, lvl_r};

   // ==================================================
   // Arbitration fields, writable by software
   // Strobes are honoured only while the clock is enabled
   genvar g;
   generate
      for (g = 0; g < NMOD; g = g + 1) begin : g_arb
         always @(posedge ref_clk or negedge resetn) begin
            if (!resetn)
               mod_arb_field[g*4 +: 4] <= `IAA_ARB_MOD_RST;
            else if (clk_en && mod_arb_wr[g])
               mod_arb_field[g*4 +: 4] <= mod_arb_wr_data[g*4 +: 4];
         end
      end
   endgenerate

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn)
         siu_arb_field <= `IAA_ARB_SIU_RST;
      else if (clk_en && siu_arb_wr)
         siu_arb_field <= siu_arb_wr_data;
   end

   // ==================================================
   // Level-7 edge detect and mask drop from 7
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         nmi_prev_r <= 1'b0;
         nmi_pend_r <= 1'b0;
         ipm_prev_r <= 3'h7;
      end else if (clk_en) begin
         nmi_prev_r <= pin_valid[7];
         ipm_prev_r <= ipm;
         // New edge, or mask falling from 7 while held; set wins over clear
         if ((pin_valid[7] && !nmi_prev_r) ||
             (pin_valid[7] && ipm_prev_r == 3'h7 && ipm != 3'h7))
            nmi_pend_r <= 1'b1;
         else if (state_r == ST_VEC && lvl_r == `IAA_LEVEL_NMI)
            nmi_pend_r <= 1'b0;
      end
   end

   // ==================================================
   // Sequencer
   // All outputs except the arbitration fields registered here; pulses default low every cycle
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_r             <= ST_IDLE;
         mon_cnt_r           <= 16'h0000;
         stk_cnt_r           <= 3'h0;
         lvl_r               <= 3'h0;
         function_code_lines <= 3'h0;
         ack_addr            <= 24'h000000;
         ack_cycle           <= 1'b0;
         ext_forward         <= 1'b0;
         bus_error_line      <= 1'b0;
         stack_push          <= 1'b0;
         stack_data          <= 32'h00000000;
         status_reg          <= `IAA_SR_RST;
         vector_addr         <= 32'h00000000;
         pc_load             <= 1'b0;
         vector_num          <= 8'h00;
         mod_ack             <= {NMOD{1'b0}};
         timer_ack           <= 1'b0;
      end else if (clk_en) begin
         stack_push     <= 1'b0;
         pc_load        <= 1'b0;
         mod_ack        <= {NMOD{1'b0}};
         timer_ack      <= 1'b0;
         bus_error_line <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               // Software load only between sequences, never mid-acknowledge
               if (sr_wr)
                  status_reg <= sr_wr_data;
               // Level not latched while pending; highest wins at start
               if (instr_boundary && top_lvl != 3'h0) begin
                  lvl_r     <= top_lvl;
                  stk_cnt_r <= 3'h0;
                  state_r   <= ST_STACK;
               end
            end
            ST_STACK: begin
               // Push SR then PC in a short fixed sequence
               stack_push <= 1'b1;
               stack_data <= (stk_cnt_r == 3'h0) ? {16'h0000, status_reg} : pc_in;
               stk_cnt_r  <= stk_cnt_r + 3'h1;
               if (stk_cnt_r == `IAA_STACK_CYC - 1) begin
                  status_reg[`IAA_SR_S_BIT]  <= 1'b1;
                  status_reg[`IAA_SR_T1_BIT] <= 1'b0;
                  status_reg[`IAA_SR_T0_BIT] <= 1'b0;
                  state_r <= ST_ACK;
               end
            end
            ST_ACK: begin
               function_code_lines <= `IAA_FC_CPU_SPACE;
               ack_addr <= {`IAA_ADDR_HI_ONES, lvl_r, `IAA_ADDR_BIT0};
               ack_cycle <= 1'b1;
               status_reg[`IAA_SR_IPM_LSB+2:`IAA_SR_IPM_LSB] <= lvl_r;
               state_r <= ST_ARB;
            end
            ST_ARB: begin
               // Contention always runs, even for a single source
               if (best_arb == `IAA_ARB_NONE) begin
                  bus_error_line <= 1'b1;
                  vector_num     <= `IAA_VEC_SPURIOUS;
                  state_r        <= ST_VEC;
               end else if (best_mod != {NMOD{1'b0}}) begin
                  // Internal winner ends the cycle; chip-select stays out
                  mod_ack    <= best_mod;
                  vector_num <= win_vec;
                  state_r    <= ST_VEC;
               end else if (tmr_hit) begin
                  // Timer ahead of pins at the same level
                  timer_ack  <= 1'b1;
                  vector_num <= win_vec;
                  state_r    <= ST_VEC;
               end else begin
                  ext_forward <= 1'b1;
                  mon_cnt_r   <= 16'h0000;
                  state_r     <= ST_EXT;
               end
            end
            ST_EXT: begin
               // Chip-select only matches once forwarded
               // Monitor restarts from zero on every forwarded cycle
               mon_cnt_r <= mon_cnt_r + 16'h0001;
               if (autovector_request || (cs_ack_match && cs_autovector)) begin
                  vector_num  <= auto_vec;
                  ext_forward <= 1'b0;
                  state_r     <= ST_VEC;
               end else if (data_size_ack || cs_ack_match) begin
                  vector_num  <= ext_vector;
                  ext_forward <= 1'b0;
                  state_r     <= ST_VEC;
               end else if (mon_cnt_r == MON_CYC - 1) begin
                  bus_error_line <= 1'b1;
                  vector_num     <= `IAA_VEC_SPURIOUS;
                  ext_forward    <= 1'b0;
                  state_r        <= ST_VEC;
               end
            end
            ST_VEC: begin
               // Close the bus cycle and form the table address
               ack_cycle           <= 1'b0;
               function_code_lines <= 3'h0;
               vector_addr <= vector_base + {22'h0, vector_num, 2'h0};
               state_r     <= ST_LOAD;
            end
            ST_LOAD: begin
               // Handler fetch starts once the program counter loads
               pc_load <= 1'b1;
               state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

endmodule // iaa_ack_arb

// File: iaa_ack_arb_assertions.sv
`timescale 1ns/1ps
// ==================================================
// Acknowledge cycle checker, sees top ports only
module iaa_chk #(
   parameter int NMOD    = 4,   // Internal modules
   parameter int MON_CYC = 64   // Bus monitor period
) (
   input wire logic             ref_clk,
   input wire logic             resetn,
   input wire logic [2:0]       function_code_lines,
   input wire logic [23:0]      ack_addr,
   input wire logic             ack_cycle,
   input wire logic             ext_forward,
   input wire logic             bus_error_line,
   input wire logic             stack_push,
   input wire logic [15:0]      status_reg,
   input wire logic [31:0]      vector_addr,
   input wire logic [31:0]      vector_base,
   input wire logic             pc_load,
   input wire logic [7:0]       vector_num,
   input wire logic [NMOD-1:0]  mod_ack,
   input wire logic             timer_ack
);
   // Monitor wait plus two cycles of answer latency
   localparam int MON_LIM = MON_CYC + 2;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // ==================================================
   // Sequences
   sequence four_pushes;  // Status word then three program counter items
      stack_push [*4];
   endsequence
   sequence arb_result;  // Some winner or a spurious bus error closes arbitration
      bus_error_line || (|mod_ack) || timer_ack || ext_forward;
   endsequence
   // ==================================================
   // Assertions
   fc_cpu_space_a: assert property (ack_cycle |-> function_code_lines == 3'h7)
      else $error("function code not cpu space");
   ack_addr_form_a: assert property (ack_cycle |-> ack_addr[23:4] == 20'hfffff && ack_addr[0])
      else $error("acknowledge address malformed");
   mask_latch_a: assert property ($rose(ack_cycle) |-> status_reg[10:8] == ack_addr[3:1])
      else $error("mask differs from acknowledged level");
   stack_order_a: assert property ($rose(stack_push) |-> four_pushes ##1 (!stack_push && ack_cycle))
      else $error("stacking not four items before acknowledge");
   super_mode_a: assert property ($rose(ack_cycle) |-> status_reg[13] && status_reg[15:14] == 2'h0)
      else $error("supervisor or trace bits wrong");
   arb_always_a: assert property ($rose(ack_cycle) |-> ##1 arb_result)
      else $error("no arbitration outcome");
   mon_bound_a: assert property ($rose(ext_forward) |-> ##[1:MON_LIM] !ext_forward)
      else $error("forwarded cycle never ended");
   inner_quiet_a: assert property ((|mod_ack) || timer_ack |-> !ext_forward [*2])
      else $error("internal winner forwarded externally");
   vec_addr_a: assert property (pc_load |-> vector_addr == vector_base + {22'h0, vector_num, 2'h0})
      else $error("vector address not base plus four times vector");
   spur_vec_a: assert property (bus_error_line |-> ##[1:3] (pc_load && vector_num == 8'h18))
      else $error("bus error without spurious vector");
endmodule // iaa_chk

bind iaa_ack_arb iaa_chk #(.NMOD(NMOD), .MON_CYC(MON_CYC)) iaa_chk_i (
   .ref_clk(ref_clk), .resetn(resetn), .function_code_lines(function_code_lines),
   .ack_addr(ack_addr), .ack_cycle(ack_cycle), .ext_forward(ext_forward),
   .bus_error_line(bus_error_line), .stack_push(stack_push), .status_reg(status_reg),
   .vector_addr(vector_addr), .vector_base(vector_base), .pc_load(pc_load),
   .vector_num(vector_num), .mod_ack(mod_ack), .timer_ack(timer_ack));

// File: iaa_defines.vh
`ifndef IAA_DEFINES_VH
`define IAA_DEFINES_VH
// ==================================================
// Arbitration priority values
`define IAA_ARB_SIU_RST    4'hf
`define IAA_ARB_MOD_RST    4'h0
`define IAA_ARB_NONE       4'h0
// ==================================================
// Acknowledge cycle encodings
`define IAA_FC_CPU_SPACE   3'h7
`define IAA_ADDR_HI_ONES   20'hfffff
`define IAA_ADDR_BIT0      1'h1
`define IAA_LEVEL_NMI      3'h7
`define IAA_LEVEL_OFF      3'h0
// ==================================================
// Status register layout and reset value
`define IAA_SR_RST         16'h2700
`define IAA_SR_T1_BIT      15
`define IAA_SR_T0_BIT      14
`define IAA_SR_S_BIT       13
`define IAA_SR_IPM_LSB     8
// ==================================================
// Vector numbers
`define IAA_VEC_SPURIOUS   8'h18
`define IAA_VEC_AUTO_BASE  8'h18
// ==================================================
// Timing: bus monitor period in ns, cycles at 50 MHz
`define IAA_CLK_NS         20
`define IAA_BUS_MON_NS     1280
`define IAA_BUS_MON_CYC    (`IAA_BUS_MON_NS / `IAA_CLK_NS)
// Stacking takes a fixed number of cycles in this model
`define IAA_STACK_CYC      4
`endif

// File: iaa_ext_dev.sv
`timescale 1ns/1ps
// ==================================================
// External interrupting device on the bus
module iaa_ext_dev (
   input  wire logic [23:0] ack_addr,
   input  wire logic        ref_clk,
   input  wire logic        ext_forward,  // Cycle is on the external bus
   input  wire logic [2:0]  level,        // Level this device requests at
   input  wire logic [1:0]  mode,         // 0 vector, 1 autovector, 2 silent
   input  wire logic [3:0]  delay,        // Wait cycles before answering
   input  wire logic [7:0]  vec,          // Vector handed back
   output logic             data_size_ack,
   output logic             autovector_request,
   output logic [7:0]       ext_vector
);
   logic [3:0] cnt_r;  // Cycles since forwarding
   initial begin
      cnt_r = 4'h0;
      data_size_ack = 1'b0;
      autovector_request = 1'b0;
      ext_vector = 8'h00;
   end
   // Answer after the wait, hold until the cycle closes
   always @(posedge ref_clk) begin
      #1;
      if (!ext_forward || ack_addr[3:1] != level) begin
         cnt_r = 4'h0;
         data_size_ack = 1'b0;
         autovector_request = 1'b0;
         ext_vector = ~ext_vector;  // Released bus inverts the last vector every cycle
      end else if (cnt_r < delay) begin
         cnt_r = cnt_r + 4'h1;
      end else if (mode == 2'h0) begin
         ext_vector = vec;
         data_size_ack = 1'b1;
      end else if (mode == 2'h1) begin
         autovector_request = 1'b1;
      end
   end
endmodule // iaa_ext_dev

// File: tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared = n_compared + 1; if ((got) !== (exp)) begin \
   miscompares = miscompares + 1; $display("unexpected %s exp %h got %h", nm, exp, got); end end
module tb_top;
   localparam [31:0] VBASE = 32'h00001000;  // Vector table base
   reg ref_clk = 1'b0, resetn = 1'b0, siu_arb_wr, timer_req, cs_ack_match, cs_autovector;
   reg instr_boundary, sr_wr;
   reg [15:0] sr_wr_data;
   reg [7:1] irq_pins_n;
   reg [11:0] mod_level;
   reg [15:0] mod_arb_wr_data;
   reg [3:0] mod_arb_wr, siu_arb_wr_data, pdly;
   reg [2:0] timer_request_level, plvl;
   reg [1:0] pmode;
   reg [7:0] pvec, hits;
   wire data_size_ack, autovector_request, ack_cycle, ext_forward, bus_error_line;
   wire stack_push, pc_load, timer_ack;
   wire [7:0] ext_vector, vector_num;
   wire [2:0] function_code_lines;
   wire [23:0] ack_addr;
   wire [31:0] vector_addr, stack_data;
   wire [15:0] status_reg, mod_arb_field;
   wire [3:0] mod_ack, siu_arb_field;
   integer miscompares = 0, n_compared = 0, k;
   // ==================================================
   // Clock and instances
   always #10 ref_clk = ~ref_clk;
   iaa_ack_arb #(.NMOD(4), .MON_CYC(4)) iaa_ack_arb_i (
      .ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1), .irq_pins_n(irq_pins_n),
      .mod_level(mod_level), .mod_arb_wr_data(mod_arb_wr_data), .mod_arb_wr(mod_arb_wr),
      .mod_vector(32'h00004100), .siu_arb_wr_data(siu_arb_wr_data), .siu_arb_wr(siu_arb_wr),
      .timer_request_level(timer_request_level), .timer_req(timer_req),
      .instr_boundary(instr_boundary), .sr_wr(sr_wr), .sr_wr_data(sr_wr_data),
      .vector_base(VBASE), .pc_in(32'h00002468), .data_size_ack(data_size_ack),
      .autovector_request(autovector_request), .ext_vector(ext_vector),
      .cs_ack_match(cs_ack_match), .cs_autovector(cs_autovector),
      .function_code_lines(function_code_lines), .ack_addr(ack_addr), .ack_cycle(ack_cycle),
      .ext_forward(ext_forward), .bus_error_line(bus_error_line), .stack_push(stack_push),
      .stack_data(stack_data), .status_reg(status_reg), .vector_addr(vector_addr),
      .pc_load(pc_load),
      .vector_num(vector_num), .mod_ack(mod_ack), .timer_ack(timer_ack),
      .mod_arb_field(mod_arb_field), .siu_arb_field(siu_arb_field));
   iaa_ext_dev iaa_ext_dev_i (.ack_addr(ack_addr), .ref_clk(ref_clk), .ext_forward(ext_forward),
      .level(plvl), .mode(pmode), .delay(pdly), .vec(pvec), .data_size_ack(data_size_ack),
      .autovector_request(autovector_request), .ext_vector(ext_vector));
   // ==================================================
   // Tasks
   task tick;  // Inputs move just after the edge
      begin
         @(posedge ref_clk);
         #1;
      end
   endtask
   task stop_test;  // Single exit of the run
      begin
         $display("compared %0d mismatched %0d", n_compared, miscompares);
         if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   // One full acknowledge sequence, then requests withdrawn
   task run_seq(input [2:0] lvl, input [3:0] exp_seen, input [7:0] exp_vec);
      reg [3:0] seen;
      reg done;
      begin
         seen = 4'h0;
         done = 1'b0;
         for (k = 0; k < 300 && !done; k = k + 1) begin
            tick;
            seen = seen | {ext_forward, bus_error_line, |mod_ack, timer_ack};
            done = (pc_load === 1'b1);
         end
         if (!done) begin  // Hang cut short
            miscompares = miscompares + 1;
            stop_test;
         end
         `CHK("winner kind", exp_seen, seen)
         `CHK("vector_addr", VBASE + {22'h0, exp_vec, 2'h0}, vector_addr)
         `CHK("mask", lvl, status_reg[10:8])
         `CHK("trace and supervisor", 3'h1, status_reg[15:13])
         `CHK("stack_data", 32'h00002468, stack_data)
         irq_pins_n = 7'h7f;
         mod_level = 12'h0;
         timer_req = 1'b0;
         cs_ack_match = 1'b0;
         cs_autovector = 1'b0;
      end
   endtask
   // ==================================================
   // Main sequence
   initial begin
      irq_pins_n = 7'h7f; mod_level = 12'h0; mod_arb_wr_data = 16'h0; mod_arb_wr = 4'h0;
      siu_arb_wr_data = 4'h0; siu_arb_wr = 1'b0; timer_request_level = 3'h0; timer_req = 1'b0;
      cs_ack_match = 1'b0; cs_autovector = 1'b0; plvl = 3'h0; pmode = 2'h2; pdly = 4'h2;
      pvec = 8'h55; hits = 8'h0;
      instr_boundary = 1'b0;
      sr_wr = 1'b0;
      sr_wr_data = 16'h0;
      repeat (6) @(posedge ref_clk);
      #1 resetn = 1'b1;
      `CHK("siu_arb_field", 4'hf, siu_arb_field)
      `CHK("mod_arb_field", 16'h0, mod_arb_field)
      `CHK("status_reg", 16'h2700, status_reg)
      sr_wr_data = 16'hc000;  // Both trace bits on, user state, mask open
      sr_wr = 1'b1;
      tick;
      sr_wr = 1'b0;
      mod_level = 12'h001;  // Module 0 requests with zero priority value
      for (k = 0; k < 10; k = k + 1) begin  // Held off until a boundary
         tick;
         if (stack_push === 1'b1) hits = hits + 8'h1;
      end
      `CHK("early pushes", 8'h0, hits)
      instr_boundary = 1'b1;
      run_seq(3'h1, 4'h4, 8'h18);
      mod_arb_wr_data = 16'h0050; mod_arb_wr = 4'h2; siu_arb_wr_data = 4'he; siu_arb_wr = 1'b1;
      tick;
      mod_arb_wr = 4'h0; siu_arb_wr = 1'b0;
      tick;
      `CHK("mod_arb_field", 16'h0050, mod_arb_field)
      `CHK("siu_arb_field", 4'he, siu_arb_field)
      mod_level = 12'h010; cs_ack_match = 1'b1;  // Chip-select armed for the same level
      run_seq(3'h2, 4'h2, 8'h41);
      irq_pins_n = 7'h7b; plvl = 3'h3; pmode = 2'h0;
      run_seq(3'h3, 4'h8, 8'h55);
      irq_pins_n = 7'h77; plvl = 3'h4; pmode = 2'h1;
      run_seq(3'h4, 4'h8, 8'h1c);
      irq_pins_n = 7'h6f; pmode = 2'h2; cs_ack_match = 1'b1; cs_autovector = 1'b1;
      run_seq(3'h5, 4'h8, 8'h1d);
      irq_pins_n = 7'h5f; timer_request_level = 3'h6; timer_req = 1'b1;
      run_seq(3'h6, 4'h1, 8'h00);
      irq_pins_n = 7'h7b; timer_request_level = 3'h0; timer_req = 1'b1;
      for (k = 0; k < 40; k = k + 1) begin  // Masked pin, disabled timer
         tick;
         if (stack_push === 1'b1) hits = hits + 8'h1;
      end
      `CHK("refused pushes", 8'h0, hits)
      irq_pins_n = 7'h3f; timer_req = 1'b0; plvl = 3'h7;  // Silent device, monitor expires
      run_seq(3'h7, 4'hc, 8'h18);
      irq_pins_n = 7'h3f;  // Level 7 held while the mask drops from 7
      sr_wr_data = 16'h2000;
      sr_wr = 1'b1;
      tick;
      sr_wr = 1'b0;
      run_seq(3'h7, 4'hc, 8'h18);
      stop_test;
   end
endmodule // tb_top
